// ### hdl/hsbi_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - four address lines pick one word bit
// - respond only while module select is low
// - capture serial-out bit at strobe rising edge
// - return data one bit on serial-in
// - interrupt output low only when service needed
// - io reset line resets whole block
// - combine host resets into one master reset
// - eight identity switch inputs form hex code
// - id code readable after host command
// - multiplex id code or status onto serial-in
module hsbi_top (
	input wire logic i_clock, // 50 MHz system clock
	input wire logic i_arst_n, // board reset, active low
	input wire logic i_io_reset_n, // host io reset pin
	input wire logic i_power_reset_n, // host power reset pin
	input wire logic i_bit_addr_line_a, // address msb
	input wire logic i_bit_addr_line_b, // address bit
	input wire logic i_bit_addr_line_c, // address bit
	input wire logic i_bit_addr_line_d, // address lsb
	input wire logic i_module_select_n, // module select pin
	input wire logic i_write_strobe_n, // store strobe pin
	input wire logic i_host_serial_out, // host to board data
	output logic o_host_serial_in, // board to host data
	output logic o_host_serial_in_oe, // high while driving serial-in
	output logic o_interrupt_request_n, // interrupt to host
	input wire logic [hsbi_pkg::ID_W-1:0] i_id_switch, // id switches
	input wire logic [hsbi_pkg::WORD_W-1:0] i_board_data, // status word
	input wire logic i_service_request, // board event pulse
	output logic [hsbi_pkg::WORD_W-1:0] o_host_word, // written bits
	output logic o_write_pulse, // one cycle per stored bit
	output logic [hsbi_pkg::ADDR_W-1:0] o_write_index, // stored bit index
	output logic o_master_reset_n // master reset for board logic
);
	import hsbi_pkg::*;

	function automatic logic rd_bit(input logic [3:0] a,
			input logic [15:0] dat, input logic [7:0] id,
			input logic id_sel);
		if (id_sel && (a < ID_ADDR_LIM)) begin
			rd_bit = id[a[2:0]];
		end else begin
			rd_bit = dat[a];
		end
	endfunction : rd_bit

	////////////////////////////////////////////////////////////////////////
	// reset: async assert, sync release
	logic comb_rst_n;
	logic [1:0] rst_r, rst_nxt;
	logic mrst_n;

	assign comb_rst_n = i_arst_n & i_io_reset_n & i_power_reset_n;

	always_comb begin
		rst_nxt = {rst_r[0], 1'b1};
	end

	always_ff @(posedge i_clock or negedge comb_rst_n) begin
		if (!comb_rst_n) begin
			rst_r <= RST_SYNC_RST;
		end else begin
			rst_r <= rst_nxt;
		end
	end

	assign mrst_n = rst_r[1];
	assign o_master_reset_n = mrst_n;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [PIN_W-1:0] pin_s;
	logic [ID_W-1:0] id_s;
	logic [ADDR_W-1:0] addr_s;
	logic sel_n_s, stb_n_s, data_s;

	hsbi_pin_sync #(.W(PIN_W), .RST(PIN_IDLE)) u_pin_sync (
		.i_clock(i_clock),
		.i_rst_n(mrst_n),
		.i_pin({i_host_serial_out, i_write_strobe_n, i_module_select_n,
			i_bit_addr_line_a, i_bit_addr_line_b, i_bit_addr_line_c,
			i_bit_addr_line_d}),
		.o_stable(pin_s)
	);

	hsbi_pin_sync #(.W(ID_W), .RST(ID_RST)) u_id_sync (
		.i_clock(i_clock),
		.i_rst_n(mrst_n),
		.i_pin(i_id_switch),
		.o_stable(id_s)
	);

	assign addr_s = pin_s[PIN_ADDR_LSB +: ADDR_W];
	assign sel_n_s = pin_s[PIN_SEL_N];
	assign stb_n_s = pin_s[PIN_STB_N];
	assign data_s = pin_s[PIN_DATA];

	////////////////////////////////////////////////////////////////////////
	// access state machine and write capture
	hsbi_state_e state_r, state_nxt;
	logic [ADDR_W-1:0] cap_addr_r, cap_addr_nxt;
	logic cap_data_r, cap_data_nxt;
	logic [WORD_W-1:0] word_r, word_nxt;
	logic wr_pulse_r, wr_pulse_nxt;
	logic [ADDR_W-1:0] wr_idx_r, wr_idx_nxt;

	always_comb begin
		state_nxt = state_r;
		cap_addr_nxt = cap_addr_r;
		cap_data_nxt = cap_data_r;
		word_nxt = word_r;
		wr_pulse_nxt = 1'b0;
		wr_idx_nxt = wr_idx_r;
		case (state_r)
			HSBI_IDLE: begin
				// strobe edges here are for other modules
				if (!sel_n_s) begin
					state_nxt = stb_n_s ? HSBI_READ : HSBI_WRITE;
				end
			end
			HSBI_READ: begin
				if (sel_n_s) begin
					state_nxt = HSBI_IDLE;
				end else if (!stb_n_s) begin
					state_nxt = HSBI_WRITE;
				end
			end
			HSBI_WRITE: begin
				if (sel_n_s) begin
					// select dropped mid-write: abandon, store nothing
					state_nxt = HSBI_IDLE;
				end else if (stb_n_s) begin
					word_nxt[cap_addr_r] = cap_data_r;
					wr_pulse_nxt = 1'b1;
					wr_idx_nxt = cap_addr_r;
					state_nxt = HSBI_READ;
				end
			end
			default: begin
				state_nxt = HSBI_IDLE;
			end
		endcase
		// keep the last values seen while the strobe is low
		if (!sel_n_s && !stb_n_s) begin
			cap_addr_nxt = addr_s;
			cap_data_nxt = data_s;
		end
	end

	always_ff @(posedge i_clock or negedge mrst_n) begin
		if (!mrst_n) begin
			state_r <= HSBI_IDLE;
			cap_addr_r <= '0;
			cap_data_r <= 1'b0;
			word_r <= WORD_RST;
			wr_pulse_r <= 1'b0;
			wr_idx_r <= '0;
		end else begin
			state_r <= state_nxt;
			cap_addr_r <= cap_addr_nxt;
			cap_data_r <= cap_data_nxt;
			word_r <= word_nxt;
			wr_pulse_r <= wr_pulse_nxt;
			wr_idx_r <= wr_idx_nxt;
		end
	end

	assign o_host_word = word_r;
	assign o_write_pulse = wr_pulse_r;
	assign o_write_index = wr_idx_r;

	////////////////////////////////////////////////////////////////////////
	// serial-in return path and interrupt
	logic sin_r, sin_nxt, oe_r, oe_nxt;
	logic pend_r, pend_nxt, irq_n_r, irq_n_nxt;
	logic ack_wr;

	assign ack_wr = wr_pulse_nxt && (cap_addr_r == BIT_IRQ_ACK) && cap_data_r;

	always_comb begin
		sin_nxt = rd_bit(addr_s, i_board_data, id_s,
			word_r[BIT_ID_SEL]);
		oe_nxt = (state_nxt == HSBI_READ);
		// a new event in the ack cycle stays pending
		pend_nxt = i_service_request | (pend_r & ~ack_wr);
		irq_n_nxt = ~(pend_r & word_r[BIT_IRQ_EN]);
	end

	always_ff @(posedge i_clock or negedge mrst_n) begin
		if (!mrst_n) begin
			sin_r <= 1'b0;
			oe_r <= 1'b0;
			pend_r <= 1'b0;
			irq_n_r <= 1'b1;
		end else begin
			sin_r <= sin_nxt;
			oe_r <= oe_nxt;
			pend_r <= pend_nxt;
			irq_n_r <= irq_n_nxt;
		end
	end

	assign o_host_serial_in = sin_r;
	assign o_host_serial_in_oe = oe_r;
	assign o_interrupt_request_n = irq_n_r;

	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!mrst_n);

	property p_store_edge;
		(state_r == HSBI_WRITE) && !sel_n_s && stb_n_s |=> o_write_pulse
			&& (o_host_word[$past(cap_addr_r)] == $past(cap_data_r));
	endproperty
	a_store_edge: assert property (p_store_edge)
		else $error("strobe rise did not store the bit");

	property p_index;
		o_write_pulse |-> o_write_index == $past(cap_addr_r);
	endproperty
	a_index: assert property (p_index)
		else $error("stored bit index differs from decoded address");

	property p_no_unsel_write;
		sel_n_s |=> !o_write_pulse;
	endproperty
	a_no_unsel_write: assert property (p_no_unsel_write)
		else $error("write taken while not selected");

	property p_oe_sel;
		o_host_serial_in_oe |-> $past(!sel_n_s) && $past(stb_n_s);
	endproperty
	a_oe_sel: assert property (p_oe_sel)
		else $error("serial-in driven while unselected or writing");

	property p_unsel_quiet;
		sel_n_s [*2] |-> !o_host_serial_in_oe;
	endproperty
	a_unsel_quiet: assert property (p_unsel_quiet)
		else $error("serial-in driven after deselect");

	property p_read_mux;
		o_host_serial_in_oe && !$past(o_host_word[BIT_ID_SEL]) |->
			o_host_serial_in == $past(i_board_data[addr_s]);
	endproperty
	a_read_mux: assert property (p_read_mux)
		else $error("serial-in does not show the addressed status bit");

	property p_id_read;
		o_host_serial_in_oe && $past(o_host_word[BIT_ID_SEL])
			&& ($past(addr_s) < ID_ADDR_LIM) |->
			o_host_serial_in == $past(id_s[addr_s[2:0]]);
	endproperty
	a_id_read: assert property (p_id_read)
		else $error("id switch bit not returned");

	property p_irq_out;
		pend_r && o_host_word[BIT_IRQ_EN] |=> !o_interrupt_request_n;
	endproperty
	a_irq_out: assert property (p_irq_out)
		else $error("pending enabled event gave no interrupt");

	property p_irq_idle;
		!pend_r ##1 !pend_r |-> o_interrupt_request_n;
	endproperty
	a_irq_idle: assert property (p_irq_idle)
		else $error("interrupt asserted with nothing pending");

	property p_set_wins;
		i_service_request |=> pend_r;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("service event lost");

	property p_master_rst;
		@(posedge i_clock) disable iff (!i_arst_n)
		!i_io_reset_n |-> !o_master_reset_n ##1 !o_master_reset_n;
	endproperty
	a_master_rst: assert property (p_master_rst)
		else $error("io reset did not reset the board");

	c_write: cover property (o_write_pulse && o_write_index == BIT_IRQ_EN);
	c_read: cover property ($rose(o_host_serial_in_oe));
	c_irq: cover property ($fell(o_interrupt_request_n));
	c_id: cover property (o_host_serial_in_oe && o_host_word[BIT_ID_SEL]);
endmodule : hsbi_top

// ### hdl/hsbi_pkg.sv
package hsbi_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 4;
	localparam int ID_W = 8;
	// host pin bundle layout, all pins pass one synchroniser
	localparam int PIN_W = 7;
	localparam int PIN_ADDR_LSB = 0;
	localparam int PIN_SEL_N = 4;
	localparam int PIN_STB_N = 5;
	localparam int PIN_DATA = 6;
	// idle level of the bundle: select and strobe high
	localparam logic [6:0] PIN_IDLE = 7'h30;
	localparam logic [7:0] ID_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [1:0] RST_SYNC_RST = 2'h0;
	// write-word bits with a meaning inside the block
	localparam logic [3:0] BIT_IRQ_EN = 4'hD;
	localparam logic [3:0] BIT_IRQ_ACK = 4'hE;
	localparam logic [3:0] BIT_ID_SEL = 4'hF;
	// id switches answer on read addresses below this
	localparam logic [3:0] ID_ADDR_LIM = 4'h8;
	typedef enum logic [2:0] {
		HSBI_IDLE = 3'h1,
		HSBI_READ = 3'h2,
		HSBI_WRITE = 3'h4
	} hsbi_state_e;
endpackage : hsbi_pkg

// ### hdl/hsbi_pin_sync.sv
`timescale 1ns/1ps
module hsbi_pin_sync #(
	parameter int W = 7,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clock, // system clock
	input wire logic i_rst_n, // master reset, active low
	input wire logic [W-1:0] i_pin, // raw asynchronous pins
	output logic [W-1:0] o_stable // level once stages two and three agree
);
	logic [W-1:0] ff1_r, ff2_r, ff3_r, stable_r;
	logic [W-1:0] stable_nxt;

	// a bit moves only when the last two stages agree, filtering a glitch
	always_comb begin
		stable_nxt = (stable_r & (ff2_r ^ ff3_r)) | (ff3_r & ~(ff2_r ^ ff3_r));
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ff1_r <= RST;
			ff2_r <= RST;
			ff3_r <= RST;
			stable_r <= RST;
		end else begin
			ff1_r <= i_pin;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
			stable_r <= stable_nxt;
		end
	end

	assign o_stable = stable_r;
endmodule : hsbi_pin_sync

// ### bench/hsbi_host_model.sv
`timescale 1ns/1ps
module hsbi_host_model (
	input wire logic i_clock, // system clock
	input wire logic i_serial_in, // board to host data
	input wire logic i_serial_in_oe, // board drives serial-in
	output logic [3:0] o_addr, // bit address, msb first
	output logic o_select_n, // module select
	output logic o_strobe_n, // store strobe
	output logic o_data // host to board data
);
	initial begin
		o_addr = 4'h0;
		o_select_n = 1'b1;
		o_strobe_n = 1'b1;
		o_data = 1'b0;
	end
	// pins take four edges to settle inside, so phases get eight
	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : step
	task automatic write_bit(input logic [3:0] a, input logic d,
			input logic sel);
		step(4);
		o_select_n = ~sel;
		o_addr = a;
		o_data = d;
		step(8);
		o_strobe_n = 1'b0;
		step(8);
		o_strobe_n = 1'b1;
		step(8);
		o_select_n = 1'b1;
		// released data line must not keep the old level
		o_data = ~d;
	endtask : write_bit
	task automatic read_bit(input logic [3:0] a, output logic q,
			output logic oe);
		step(4);
		o_select_n = 1'b0;
		o_addr = a;
		step(8);
		// no keeper on an undriven line: show the opposite level
		q = i_serial_in_oe ? i_serial_in : ~i_serial_in;
		oe = i_serial_in_oe;
		o_select_n = 1'b1;
	endtask : read_bit
endmodule : hsbi_host_model

// ### bench/test_host_serial_bit_interface.sv
`timescale 1ns/1ps
module test_host_serial_bit_interface;
	import hsbi_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic io_rst_n, pwr_rst_n, svc;
	logic [7:0] id_sw;
	logic [15:0] brd;
	logic [3:0] addr;
	logic sel_n, stb_n, sdo, sdi, sdi_oe, irq_n, wp, mrst_n;
	logic [15:0] word, exp_w;
	logic [3:0] widx;
	int mismatches = 0;
	int n_compared = 0;
	int pulses = 0;
	int p0;
	logic q, oe;
	always #10 clk = ~clk;
	always @(posedge clk) if (wp === 1'b1) pulses++;
	hsbi_top u_dut (.i_clock(clk), .i_arst_n(arst_n),
		.i_io_reset_n(io_rst_n), .i_power_reset_n(pwr_rst_n),
		.i_bit_addr_line_a(addr[3]), .i_bit_addr_line_b(addr[2]),
		.i_bit_addr_line_c(addr[1]), .i_bit_addr_line_d(addr[0]),
		.i_module_select_n(sel_n), .i_write_strobe_n(stb_n),
		.i_host_serial_out(sdo), .o_host_serial_in(sdi),
		.o_host_serial_in_oe(sdi_oe), .o_interrupt_request_n(irq_n),
		.i_id_switch(id_sw), .i_board_data(brd),
		.i_service_request(svc), .o_host_word(word),
		.o_write_pulse(wp), .o_write_index(widx),
		.o_master_reset_n(mrst_n));
	hsbi_host_model u_host (.i_clock(clk), .i_serial_in(sdi),
		.i_serial_in_oe(sdi_oe), .o_addr(addr), .o_select_n(sel_n),
		.o_strobe_n(stb_n), .o_data(sdo));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
			input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t %s", $time, what);
		end
	endtask : check
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [3:0] a, input logic d);
		p0 = pulses;
		u_host.write_bit(a, d, 1'b1);
		exp_w[a] = d;
		check(word, exp_w, "stored word");
		check(widx, a, "stored index");
		check(16'(pulses - p0), 16'h0001, "one write pulse");
	endtask : wr
	////////////////////////////////////////////////////////////////////////
	task automatic t_write;
		for (int i = 0; i < 13; i++) wr(i[3:0], (i % 3) == 0);
		$display("write done");
	endtask : t_write
	task automatic t_read;
		// second pass on a new status word: the mux must follow it
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 16; i++) begin
				u_host.read_bit(i[3:0], q, oe);
				check(q, brd[i], "read bit");
				check(oe, 1'b1, "drive while selected");
			end
			brd = 16'h3C5A;
		end
		u_host.step(8);
		check(sdi_oe, 1'b0, "released when idle");
		$display("read done");
	endtask : t_read
	task automatic t_unsel;
		p0 = pulses;
		u_host.write_bit(4'h2, ~exp_w[2], 1'b0);
		check(word, exp_w, "unselected strobe");
		check(16'(pulses - p0), 16'h0000, "no pulse");
		$display("unselected done");
	endtask : t_unsel
	task automatic t_id;
		wr(4'hF, 1'b1);
		// switches moved between passes: the code is read live
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 9; i++) begin
				u_host.read_bit(i[3:0], q, oe);
				check(q, i < 8 ? id_sw[i] : brd[i], "id read");
			end
			id_sw = 8'hC3;
		end
		wr(4'hF, 1'b0);
		$display("id done");
	endtask : t_id
	task automatic t_irq;
		@(posedge clk) #1 svc = 1'b1;
		@(posedge clk) #1 svc = 1'b0;
		u_host.step(4);
		check(irq_n, 1'b1, "masked request");
		wr(4'hD, 1'b1);
		check(irq_n, 1'b0, "enabled request");
		wr(4'hE, 1'b1);
		check(irq_n, 1'b1, "acknowledged");
		$display("interrupt done");
	endtask : t_irq
	task automatic t_mreset;
		@(posedge clk) #1 io_rst_n = 1'b0;
		u_host.step(2);
		check(mrst_n, 1'b0, "io reset");
		check(word, 16'h0000, "word cleared");
		io_rst_n = 1'b1;
		u_host.step(6);
		check(mrst_n, 1'b1, "io reset released");
		pwr_rst_n = 1'b0;
		u_host.step(2);
		check(mrst_n, 1'b0, "power reset");
		pwr_rst_n = 1'b1;
		u_host.step(6);
		check(mrst_n, 1'b1, "power reset released");
		$display("master reset done");
	endtask : t_mreset
	////////////////////////////////////////////////////////////////////////
	initial begin
		io_rst_n = 1'b1;
		pwr_rst_n = 1'b1;
		svc = 1'b0;
		id_sw = 8'h5A;
		brd = 16'hA5C3;
		exp_w = WORD_RST;
		repeat (12) @(posedge clk);
		#1 arst_n = 1'b1;
		u_host.step(6);
		check(mrst_n, 1'b1, "reset released");
		check(irq_n, 1'b1, "irq idle");
		check(word, WORD_RST, "word at reset");
		t_write;
		t_read;
		t_unsel;
		t_id;
		t_irq;
		t_mreset;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test;
	end
endmodule : test_host_serial_bit_interface
